//--- core/pawc_top.sv
// Wait state generator for CPU accesses to slow peripheral registers
`timescale 1ns/1ps
`default_nettype none
`include "pawc_defines.svh"

module pawc_top #(
  parameter int unsigned SET_W = 2   // Width of the wait setting
) (
  input  wire logic                clock_i,              // CPU clock, 25 MHz
  input  wire logic                rstn_i,               // Async reset, active low
  input  wire logic                acc_valid_i,          // Access pending
  input  wire logic                acc_write_i,          // 1 write, 0 read
  input  wire logic [7:0]          acc_addr_i,           // SFR address
  input  wire logic [7:0]          acc_wdata_i,          // Write data
  input  wire pawc_pkg::pawc_div_e cpu_div_i,            // CPU clock divide code
  input  wire logic [SET_W-1:0]    wait_setting_i,       // Peripheral wait setting
  output logic                     acc_ready_o,          // Access done, one pulse
  output logic                     stall_o,              // CPU held off
  output logic                     macro_clock_select_o, // Macro clock select bit
  output pawc_pkg::pawc_wait_t     last_wait_o           // Waits of last access
);
  import pawc_pkg::*;

  // Sum wide enough that no setting can wrap a long wait into a short one
  localparam int unsigned SUM_W    = ((SET_W > PAWC_WAIT_W) ? SET_W : PAWC_WAIT_W) + 1;
  localparam pawc_wait_t  WAIT_MAX = '1;

  typedef struct packed {
    pawc_state_e state;
    logic        macro_sel;
    logic        ready;
    logic        stall;
    pawc_wait_t  last_wait;
    logic        pend_mode;  // Accepted access writes the mode register
    logic        pend_sel;   // Select bit carried by that write
  } pawc_top_s;

  // Whole state in one register, next value built below
  pawc_top_s s_q;
  pawc_top_s s_d;

  // Counter times the stall so the sequencer needs only two states
  pawc_wait_if wif ();

  pawc_wait_counter u_counter (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .wif     (wif.cnt)
  );

  // Which wait-generating register, if any, this access reaches
  function automatic pawc_class_e classify(input logic [7:0] addr, input logic wr);
    pawc_class_e cls;
    cls = PAWC_CLS_PLAIN;
    unique case (addr)
      `PAWC_ADDR_WATCHDOG_MODE:
      begin
        if (wr)
        begin
          cls = PAWC_CLS_WATCHDOG;
        end
      end
      `PAWC_ADDR_SERIAL_RX_BUF:
      begin
        if (!wr)
        begin
          cls = PAWC_CLS_SERIAL;
        end
      end
      `PAWC_ADDR_CONV_MODE,
      `PAWC_ADDR_CONV_CHAN_SEL,
      `PAWC_ADDR_COMPARE_MODE,
      `PAWC_ADDR_COMPARE_THRESH:
      begin
        if (wr)
        begin
          cls = PAWC_CLS_CONV_CTL;
        end
      end
      `PAWC_ADDR_CONV_RESULT:
      begin
        if (!wr)
        begin
          cls = PAWC_CLS_CONV_RES;
        end
      end
      default:
      begin
        cls = PAWC_CLS_PLAIN;
      end
    endcase
    return cls;
  endfunction

  // Mode register write: its completion updates the macro clock select
  function automatic logic is_mode_write(input logic [7:0] addr, input logic wr);
    logic hit;
    hit = 1'b0;
    if (wr && (addr == `PAWC_ADDR_CONV_MODE))
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Converter wait with fast macro clock (fx/2). Entries are the worst case
  // of two macro periods plus one, with a computed one already taken as none.
  function automatic pawc_wait_t conv_wait_fast(input pawc_div_e div);
    pawc_wait_t w;
    w = `PAWC_WAIT_NONE;
    unique case (div)
      PAWC_DIV1:  w = `PAWC_CONV_FAST_DIV1;
      PAWC_DIV2:  w = `PAWC_CONV_FAST_DIV2;
      PAWC_DIV4:  w = `PAWC_CONV_FAST_DIV4;
      PAWC_DIV8:  w = `PAWC_CONV_FAST_DIV8;
      PAWC_DIV16: w = `PAWC_CONV_FAST_DIV16;
      default:    w = `PAWC_CONV_FAST_DIV16;
    endcase
    return w;
  endfunction

  // Converter wait with slow macro clock (fx/4)
  function automatic pawc_wait_t conv_wait_slow(input pawc_div_e div);
    pawc_wait_t w;
    w = `PAWC_WAIT_NONE;
    unique case (div)
      PAWC_DIV1:  w = `PAWC_CONV_SLOW_DIV1;
      PAWC_DIV2:  w = `PAWC_CONV_SLOW_DIV2;
      PAWC_DIV4:  w = `PAWC_CONV_SLOW_DIV4;
      PAWC_DIV8:  w = `PAWC_CONV_SLOW_DIV8;
      PAWC_DIV16: w = `PAWC_CONV_SLOW_DIV16;
      default:    w = `PAWC_CONV_SLOW_DIV16;
    endcase
    return w;
  endfunction

  // Base wait count for an access class at setting zero
  function automatic pawc_wait_t base_wait(input pawc_class_e cls,
                                           input logic        fast,
                                           input pawc_div_e   div);
    pawc_wait_t w;
    pawc_wait_t tab;
    w   = `PAWC_WAIT_NONE;
    tab = fast ? conv_wait_fast(div) : conv_wait_slow(div);
    unique case (cls)
      PAWC_CLS_WATCHDOG:
      begin
        w = `PAWC_WAIT_WATCHDOG;
      end
      PAWC_CLS_SERIAL:
      begin
        w = `PAWC_WAIT_SERIAL_RX;
      end
      PAWC_CLS_CONV_CTL:
      begin
        w = tab;
      end
      PAWC_CLS_CONV_RES:
      begin
        // Result read never drops below one wait
        w = (tab == `PAWC_WAIT_NONE) ? `PAWC_WAIT_RESULT_MIN : tab;
      end
      PAWC_CLS_PLAIN:
      begin
        w = `PAWC_WAIT_NONE;
      end
      default:
      begin
        w = `PAWC_WAIT_NONE;
      end
    endcase
    return w;
  endfunction

  // Decode of the access presented this cycle
  pawc_class_e      acc_cls;
  pawc_wait_t       acc_base;
  pawc_wait_t       acc_wait;
  logic [SUM_W-1:0] acc_sum;
  logic             acc_take;
  logic             take_mode;
  logic             take_sel;

  always_comb
  begin
    acc_cls   = classify(acc_addr_i, acc_write_i);
    // Divide code is read at take only; a change mid-wait cannot shorten it
    acc_base  = base_wait(acc_cls, s_q.macro_sel, cpu_div_i);
    acc_sum   = SUM_W'(acc_base) + SUM_W'(wait_setting_i);
    // Nonzero setting lengthens only accesses that already wait
    if (acc_base == `PAWC_WAIT_NONE)
    begin
      acc_wait = `PAWC_WAIT_NONE;
    end
    else if (acc_sum > SUM_W'(WAIT_MAX))
    begin
      // Only a setting at least as wide as the count reaches this; clamp, never wrap
      acc_wait = WAIT_MAX;
    end
    else
    begin
      acc_wait = acc_sum[PAWC_WAIT_W-1:0];
    end
    // The cycle where ready shows still carries the finished access
    acc_take  = acc_valid_i && !s_q.ready && (s_q.state == PAWC_ST_IDLE);
    take_mode = is_mode_write(acc_addr_i, acc_write_i);
    take_sel  = acc_wdata_i[`PAWC_MACRO_SEL_BIT];
  end

  // Two-state sequencer; the counter decides when a wait ends
  always_comb
  begin
    s_d          = s_q;
    s_d.ready    = 1'b0;
    wif.load     = 1'b0;
    wif.load_val = `PAWC_WAIT_NONE;
    unique case (s_q.state)
      PAWC_ST_IDLE:
      begin
        if (acc_take)
        begin
          s_d.last_wait = acc_wait;
          s_d.pend_mode = take_mode;
          s_d.pend_sel  = take_sel;
          if (acc_wait == `PAWC_WAIT_NONE)
          begin
            s_d.ready = 1'b1;
            // No wait: a mode write completes at the take edge
            if (take_mode)
            begin
              s_d.macro_sel = take_sel;
            end
          end
          else
          begin
            wif.load     = 1'b1;
            wif.load_val = acc_wait;
            s_d.stall    = 1'b1;
            s_d.state    = PAWC_ST_WAIT;
          end
        end
      end
      PAWC_ST_WAIT:
      begin
        // Each held cycle is a retry across the unrelated peripheral clock
        if (wif.last)
        begin
          s_d.stall = 1'b0;
          s_d.ready = 1'b1;
          s_d.state = PAWC_ST_IDLE;
          // Bit captured at take, so inputs let go early cannot corrupt it
          if (s_q.pend_mode)
          begin
            s_d.macro_sel = s_q.pend_sel;
          end
        end
      end
    endcase
  end

  // Reset leaves the macro clock at its slow setting
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_q.state     <= PAWC_ST_IDLE;
      s_q.macro_sel <= `PAWC_MACRO_SEL_RST;
      s_q.ready     <= 1'b0;
      s_q.stall     <= 1'b0;
      s_q.last_wait <= `PAWC_WAIT_NONE;
      s_q.pend_mode <= 1'b0;
      s_q.pend_sel  <= `PAWC_MACRO_SEL_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Every output straight from the state register
  assign acc_ready_o          = s_q.ready;
  assign stall_o              = s_q.stall;
  assign macro_clock_select_o = s_q.macro_sel;
  assign last_wait_o          = s_q.last_wait;
endmodule
`default_nettype wire

//--- include/pawc_defines.svh
// Constants for the peripheral access wait control block
`ifndef PAWC_DEFINES_SVH
`define PAWC_DEFINES_SVH

// Special function register addresses on the CPU bus
`define PAWC_ADDR_WATCHDOG_MODE    8'hF9
`define PAWC_ADDR_SERIAL_RX_BUF    8'h12
`define PAWC_ADDR_CONV_MODE        8'h28
`define PAWC_ADDR_CONV_CHAN_SEL    8'h29
`define PAWC_ADDR_COMPARE_MODE     8'h2A
`define PAWC_ADDR_COMPARE_THRESH   8'h2B
`define PAWC_ADDR_CONV_RESULT      8'h2C

// Macro clock select bit position in the converter mode register
`define PAWC_MACRO_SEL_BIT         5
`define PAWC_MACRO_SEL_RST         1'b0

// Fixed wait counts, CPU clocks
`define PAWC_WAIT_NONE             5'h00
`define PAWC_WAIT_WATCHDOG         5'h03
`define PAWC_WAIT_SERIAL_RX        5'h01
`define PAWC_WAIT_RESULT_MIN       5'h01

// Converter wait table, macro clock select = 0, CPU clock fx/1 .. fx/16
`define PAWC_CONV_SLOW_DIV1        5'h09
`define PAWC_CONV_SLOW_DIV2        5'h05
`define PAWC_CONV_SLOW_DIV4        5'h03
`define PAWC_CONV_SLOW_DIV8        5'h02
`define PAWC_CONV_SLOW_DIV16       5'h00

// Converter wait table, macro clock select = 1
`define PAWC_CONV_FAST_DIV1        5'h05
`define PAWC_CONV_FAST_DIV2        5'h03
`define PAWC_CONV_FAST_DIV4        5'h02
`define PAWC_CONV_FAST_DIV8        5'h00
`define PAWC_CONV_FAST_DIV16       5'h00

`endif

//--- include/pawc_pkg.sv
// Types for the peripheral access wait control block
package pawc_pkg;

  localparam int unsigned PAWC_WAIT_W = 5;

  typedef logic [PAWC_WAIT_W-1:0] pawc_wait_t;

  // CPU clock division code: fx divided by 2**code
  typedef enum logic [2:0] {
    PAWC_DIV1  = 3'h0,
    PAWC_DIV2  = 3'h1,
    PAWC_DIV4  = 3'h2,
    PAWC_DIV8  = 3'h3,
    PAWC_DIV16 = 3'h4
  } pawc_div_e;

  typedef enum logic [2:0] {
    PAWC_CLS_PLAIN    = 3'h0,
    PAWC_CLS_WATCHDOG = 3'h1,
    PAWC_CLS_SERIAL   = 3'h2,
    PAWC_CLS_CONV_CTL = 3'h3,
    PAWC_CLS_CONV_RES = 3'h4
  } pawc_class_e;

  typedef enum logic [0:0] {
    PAWC_ST_IDLE = 1'b0,
    PAWC_ST_WAIT = 1'b1
  } pawc_state_e;

endpackage

//--- include/pawc_wait_if.sv
// Carrier between the wait sequencer and its cycle counter
`timescale 1ns/1ps
`default_nettype none
interface pawc_wait_if;
  import pawc_pkg::*;
  logic       load;
  pawc_wait_t load_val;
  logic       last;

  modport ctrl (output load, output load_val, input last);
  modport cnt  (input load, input load_val, output last);
endinterface
`default_nettype wire

//--- core/pawc_wait_counter.sv
// Down counter that times the inserted CPU wait cycles
`timescale 1ns/1ps
`default_nettype none
module pawc_wait_counter (
  input  wire logic  clock_i,  // CPU clock
  input  wire logic  rstn_i,   // Async reset, active low
  pawc_wait_if.cnt   wif       // Load and expiry
);
  import pawc_pkg::*;

  typedef struct packed {
    pawc_wait_t cnt;
  } pawc_cnt_s;

  pawc_cnt_s s_q;
  pawc_cnt_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (wif.load)
    begin
      s_d.cnt = wif.load_val;
    end
    else if (s_q.cnt != `PAWC_WAIT_NONE)
    begin
      s_d.cnt = s_q.cnt - pawc_wait_t'(1);
    end
  end

  assign wif.last = (s_q.cnt == pawc_wait_t'(1));

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

//--- dv/pawc_properties.sv
// Timing checker for the wait generator ports
`timescale 1ns/1ps
`default_nettype none
module pawc_properties #(
  parameter int unsigned SET_W = 2   // Wait setting width
) (
  input wire logic                clock_i,              // CPU clock
  input wire logic                rstn_i,               // Reset, active low
  input wire logic                acc_valid_i,          // Access pending
  input wire logic                acc_write_i,          // Write strobe
  input wire logic [7:0]          acc_addr_i,           // Address
  input wire logic [7:0]          acc_wdata_i,          // Write data
  input wire pawc_pkg::pawc_div_e cpu_div_i,            // Divide code
  input wire logic [SET_W-1:0]    wait_setting_i,       // Wait setting
  input wire logic                acc_ready_o,          // Done pulse
  input wire logic                stall_o,              // CPU held
  input wire logic                macro_clock_select_o, // Macro select
  input wire pawc_pkg::pawc_wait_t last_wait_o          // Last wait
);
  import pawc_pkg::*;
  logic take;
  // Only setting zero gives the plain counts
  assign take = acc_valid_i && !stall_o && !acc_ready_o && !(|wait_setting_i);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  ready_pulse_a: assert property (acc_ready_o |=> !acc_ready_o)
    else $error("ready held longer than one cycle");
  stall_end_a: assert property ($fell(stall_o) |-> acc_ready_o)
    else $error("stall ended without ready");
  stall_bound_a: assert property (stall_o |-> ##[1:12] acc_ready_o)
    else $error("stall never released");
  wdog_wait_a: assert property (take && acc_write_i && acc_addr_i == 8'hF9 |=>
    stall_o [*3] ##1 (acc_ready_o && last_wait_o == 5'h03))
    else $error("watchdog write wait wrong");
  serial_wait_a: assert property (take && !acc_write_i && acc_addr_i == 8'h12 |=>
    stall_o ##1 acc_ready_o) else $error("serial read wait wrong");
  plain_nowait_a: assert property (take && acc_addr_i[7:4] == 4'h0 |=>
    acc_ready_o && !stall_o && last_wait_o == 5'h00) else $error("plain access waited");
  conv_slow_a: assert property (take && acc_write_i && acc_addr_i == 8'h28 &&
    !macro_clock_select_o && cpu_div_i == PAWC_DIV1 |=> stall_o [*8] ##1 stall_o ##1 acc_ready_o)
    else $error("slow converter wait wrong");
  conv_fast_a: assert property (take && acc_write_i && acc_addr_i == 8'h29 &&
    macro_clock_select_o && cpu_div_i == PAWC_DIV8 |=> acc_ready_o && !stall_o)
    else $error("fast converter write waited");
  result_min_a: assert property (take && !acc_write_i && acc_addr_i == 8'h2C &&
    macro_clock_select_o && cpu_div_i == PAWC_DIV16 |=> stall_o ##1 acc_ready_o)
    else $error("result read lost its wait");
  macro_upd_a: assert property ($changed(macro_clock_select_o) |-> acc_ready_o)
    else $error("macro select changed outside completion");
endmodule
bind pawc_top pawc_properties #(.SET_W(SET_W)) u_props (.clock_i(clock_i), .rstn_i(rstn_i),
  .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i), .acc_addr_i(acc_addr_i),
  .acc_wdata_i(acc_wdata_i), .cpu_div_i(cpu_div_i), .wait_setting_i(wait_setting_i),
  .acc_ready_o(acc_ready_o), .stall_o(stall_o), .macro_clock_select_o(macro_clock_select_o),
  .last_wait_o(last_wait_o));
`default_nettype wire

//--- dv/pawc_cpu_model.sv
// CPU core model issuing held register accesses
`timescale 1ns/1ps
`default_nettype none
module pawc_cpu_model (
  input  wire logic       clock_i,     // CPU clock
  input  wire logic       acc_ready_i, // Access done
  input  wire logic       stall_i,     // CPU held
  output logic            acc_valid_o, // Access pending
  output logic            acc_write_o, // Write strobe
  output logic [7:0]      acc_addr_o,  // Address
  output logic [7:0]      acc_wdata_o  // Write data
);
  initial
  begin
    acc_valid_o = 1'b0;
    acc_write_o = 1'b0;
    acc_addr_o = 8'h00;
    acc_wdata_o = 8'h00;
  end
  // Request held until ready seen; counts stalled cycles
  task automatic access(input logic w, input logic [7:0] a, d, output int n);
    n = 0;
    acc_write_o = w;
    acc_addr_o = a;
    acc_wdata_o = d;
    acc_valid_o = 1'b1;
    do
    begin
      @(posedge clock_i);
      #1;
      n += int'(stall_i);
    end
    while (acc_ready_i !== 1'b1 && n < 16);
    @(posedge clock_i);
    #1;
  endtask
  // Released lines inverted so a stale value cannot pass
  task automatic idle();
    acc_valid_o = 1'b0;
    acc_write_o = ~acc_write_o;
    acc_addr_o = ~acc_addr_o;
    acc_wdata_o = ~acc_wdata_o;
    // One edge passes so a following request is a change, not a rewrite
    @(posedge clock_i);
    #1;
  endtask
endmodule
`default_nettype wire

//--- dv/pawc_bench.sv
// Self-checking testbench for the wait generator
`timescale 1ns/1ps
`default_nettype none
module pawc_bench;
  import pawc_pkg::*;
  logic       clock_i = 1'b0;
  logic       rstn_i = 1'b0;
  pawc_div_e  cpu_div = PAWC_DIV16;
  logic [1:0] wset = 2'h0;
  logic       valid, wr, rdy, stall, msel;
  logic [7:0] addr, wdata;
  pawc_wait_t lw;
  int         error_cnt = 0;
  int         checked = 0;
  int         n;
  always #20 clock_i = ~clock_i;
  pawc_top u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .acc_valid_i(valid), .acc_write_i(wr),
    .acc_addr_i(addr), .acc_wdata_i(wdata), .cpu_div_i(cpu_div), .wait_setting_i(wset),
    .acc_ready_o(rdy), .stall_o(stall), .macro_clock_select_o(msel), .last_wait_o(lw));
  pawc_cpu_model u_cpu (.clock_i(clock_i), .acc_ready_i(rdy), .stall_i(stall),
    .acc_valid_o(valid), .acc_write_o(wr), .acc_addr_o(addr), .acc_wdata_o(wdata));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d, input logic [7:0] exp);
    u_cpu.access(w, a, d, n);
    chk("stall cycles", 8'(n), exp);
    chk("last wait", {3'h0, lw}, exp);
  endtask
  task automatic t_reset();
    chk("ready", {7'h0, rdy}, 8'h00);
    chk("macro select", {7'h0, msel}, 8'h00);
    chk("stall", {7'h0, stall}, 8'h00);
    chk("last wait", {3'h0, lw}, 8'h00);
  endtask
  // Back to back, other direction of waiting addresses too
  task automatic t_fixed();
    acc(1'b1, 8'hF9, 8'h5A, 8'h03);
    acc(1'b0, 8'hF9, 8'h00, 8'h00);
    acc(1'b0, 8'h12, 8'h00, 8'h01);
    acc(1'b1, 8'h12, 8'hA5, 8'h00);
    acc(1'b1, 8'h05, 8'h3C, 8'h00);
    acc(1'b0, 8'h07, 8'h00, 8'h00);
    u_cpu.idle();
  endtask
  task automatic t_conv();
    logic [7:0] tbl [2][5] = '{'{8'h09, 8'h05, 8'h03, 8'h02, 8'h00},
                               '{8'h05, 8'h03, 8'h02, 8'h00, 8'h00}};
    for (int f = 0; f < 2; f++)
    begin
      cpu_div = PAWC_DIV16;
      acc(1'b1, 8'h28, {2'h0, f[0], 5'h00}, 8'h00);
      chk("macro select", {7'h0, msel}, {7'h0, f[0]});
      for (int k = 0; k < 5; k++)
      begin
        cpu_div = pawc_div_e'(k);
        for (int r = 0; r < 4; r++)
          acc(1'b1, 8'h28 + 8'(r), {2'h0, f[0], 5'h00}, tbl[f][k]);
        acc(1'b0, 8'h2C, 8'h00, (tbl[f][k] == 8'h00) ? 8'h01 : tbl[f][k]);
      end
    end
    // Unused divide codes run as the slowest CPU clock
    cpu_div = pawc_div_e'(3'h7);
    acc(1'b0, 8'h2C, 8'h00, 8'h01);
    u_cpu.idle();
  endtask
  // Mid-run reset drops the fast macro select back to slow
  task automatic t_reset_mid();
    rstn_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    t_reset();
  endtask
  // Nonzero setting stretches waits, leaves plain accesses alone
  task automatic t_setting();
    wset = 2'h1;
    acc(1'b1, 8'hF9, 8'h00, 8'h04);
    acc(1'b1, 8'h06, 8'h00, 8'h00);
    u_cpu.idle();
    wset = 2'h0;
  endtask
  initial
  begin
    repeat (2) @(posedge clock_i);
    #1;
    rstn_i = 1'b1;
    t_reset();
    t_fixed();
    t_conv();
    t_reset_mid();
    t_setting();
    stop_test();
  end
  initial
  begin
    #200000;
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
